// File: shared/eba_pkg.sv
// constants and types for the external bus arbitration and idle-insertion block
// assumes a single clock domain; all link pins arrive already synchronous
package eba_pkg;

  // chip-select space that partial-share master mode arbitrates for
  localparam logic [1:0] CS_SHARED = 2'h2;
  // largest idle count that may be inserted after a read
  localparam logic [1:0] IDLE_MAX = 2'h2;
  // encoding of the reserved idle-count code
  localparam logic [1:0] IDLE_CODE_TOP = 2'h3;
  // least wait between a read and a following write
  localparam logic [1:0] WR_AFTER_RD_MIN = 2'h1;
  // saturation value of the empty-cycle counter
  localparam logic [1:0] GAP_SAT = 2'h3;

  // internal bus masters
  typedef enum logic [1:0] {
    M_REFRESH,
    M_DMA,
    M_CPU
  } eba_master_t;

  // ownership and cycle sequencing
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GAP,
    ST_CYCLE,
    ST_RELEASE,
    ST_RELEASED,
    ST_REQUEST,
    ST_ACQUIRE
  } eba_state_t;

endpackage : eba_pkg

// File: rtl/eba_arbiter.sv
// external bus ownership: idle insertion after reads and arbitration between masters
// assumes requesters hold their request until they see their start pulse,
// and acc_done_i marks the last cycle of each external access.
`timescale 1ns/1ps
module eba_arbiter (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // mode selection
  input wire logic mode_slave_i,
  input wire logic partial_share_enable_i,
  // idle counts after reads, per space
  input wire logic [1:0] space0_read_idle_count_i,
  input wire logic [1:0] space1_read_idle_count_i,
  input wire logic [1:0] space2_read_idle_count_i,
  input wire logic [1:0] space3_read_idle_count_i,
  // internal requesters
  input wire logic refresh_req_i,
  input wire logic dma_req_i,
  input wire logic [1:0] dma_cs_i,
  input wire logic dma_wr_i,
  input wire logic dma_last_i,
  input wire logic cpu_req_i,
  input wire logic [1:0] cpu_cs_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_last_i,
  // external cycle sequencing
  input wire logic acc_done_i,
  output logic start_o,
  output logic [2:0] start_master_o,
  output logic [1:0] cyc_cs_o,
  output logic cyc_wr_o,
  output logic rd_strobe_late_o,
  output logic idle_insert_o,
  // arbitration link
  input wire logic release_request_n_i,
  output logic release_grant_n_o,
  output logic bus_request_n_o,
  input wire logic bus_ack_n_i,
  output logic bus_drive_en_n_o,
  output logic ctrl_inactive_o,
  // internal bus and cache
  input wire logic monitor_en_i,
  input wire logic periph_req_i,
  output logic periph_go_o,
  input wire logic cpu_read_hit_i,
  output logic cache_read_go_o
);

  eba_pkg::eba_state_t state_q, state_d;
  eba_pkg::eba_master_t sel_m, cur_m_q, lock_m_q;
  logic slave_q, strap_done_q, pshare, plain_master, ext_req, ref_ok;
  logic sel_valid, sel_wr, sel_last, sel_is_ref, need_share;
  logic [1:0] sel_cs, need, gap_left_q, gap_q, prev_cs_q;
  logic prev_valid_q, prev_rd_q, lock_q, shared_own_q, cur_last_q, cur_ref_q;
  logic start_q, late_q, grant_n_q, bus_request_n_n_q, decide;
  logic [1:0] cur_cs_q;
  logic cur_wr_q;
  logic [1:0] idle_cfg [4];

  function automatic logic [1:0] idle_need(input logic ok, input logic prd, input logic [1:0] pcs,
                                           input logic [1:0] ncs, input logic nwr, input logic [1:0] gap,
                                           input logic [1:0] cfg);
    logic [1:0] cnt;
    logic [1:0] rem;
    cnt = (cfg == eba_pkg::IDLE_CODE_TOP) ? eba_pkg::IDLE_MAX : cfg;
    rem = (gap >= cnt) ? 2'h0 : 2'(cnt - gap);
    if (!ok || !prd) begin
      rem = 2'h0;
    end else if (!nwr && ncs == pcs) begin
      rem = 2'h0;
    end else if (nwr && gap == 2'h0 && rem < eba_pkg::WR_AFTER_RD_MIN) begin
      rem = eba_pkg::WR_AFTER_RD_MIN;
    end
    return rem;
  endfunction : idle_need

  assign idle_cfg[0] = space0_read_idle_count_i;
  assign idle_cfg[1] = space1_read_idle_count_i;
  assign idle_cfg[2] = space2_read_idle_count_i;
  assign idle_cfg[3] = space3_read_idle_count_i;

  // mode strap caught after reset release; partial-share only from master
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slave_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      slave_q <= mode_slave_i;
      strap_done_q <= 1'b1;
    end
  end

  assign pshare = partial_share_enable_i & ~slave_q;
  assign plain_master = ~slave_q & ~pshare;
  assign ext_req = ~release_request_n_i & plain_master;
  // refresh belongs to the master side; a slave ignores it
  assign ref_ok = refresh_req_i & ~slave_q;

  // a locked sequence keeps its master; otherwise fixed priority
  always_comb begin
    sel_m = eba_pkg::M_CPU;
    sel_valid = 1'b0;
    if (lock_q) begin
      sel_m = lock_m_q;
      sel_valid = (lock_m_q == eba_pkg::M_DMA) ? dma_req_i : cpu_req_i;
    end else if (ref_ok) begin
      sel_m = eba_pkg::M_REFRESH;
      sel_valid = 1'b1;
    end else if (dma_req_i) begin
      sel_m = eba_pkg::M_DMA;
      sel_valid = 1'b1;
    end else if (cpu_req_i) begin
      sel_m = eba_pkg::M_CPU;
      sel_valid = 1'b1;
    end
  end

  assign sel_is_ref = (sel_m == eba_pkg::M_REFRESH);
  assign sel_cs = (sel_m == eba_pkg::M_DMA) ? dma_cs_i : cpu_cs_i;
  assign sel_wr = (sel_m == eba_pkg::M_DMA) ? dma_wr_i : cpu_wr_i;
  assign sel_last = sel_is_ref | ((sel_m == eba_pkg::M_DMA) ? dma_last_i : cpu_last_i);
  assign need_share = slave_q | (pshare & ~sel_is_ref & sel_cs == eba_pkg::CS_SHARED);
  // refresh carries no data, so no idle cycles are ever inserted before it
  assign need = sel_is_ref ? 2'h0 :
                idle_need(prev_valid_q, prev_rd_q, prev_cs_q, sel_cs, sel_wr, gap_q, idle_cfg[prev_cs_q]);

  always_comb begin
    state_d = state_q;
    case (state_q)
      eba_pkg::ST_IDLE: begin
        if (!strap_done_q) begin
          state_d = eba_pkg::ST_IDLE;
        end else if (ext_req && !ref_ok && !lock_q) begin
          state_d = eba_pkg::ST_RELEASE;
        end else if (sel_valid && need_share && !shared_own_q) begin
          state_d = eba_pkg::ST_REQUEST;
        end else if (sel_valid) begin
          state_d = (need != 2'h0) ? eba_pkg::ST_GAP : eba_pkg::ST_CYCLE;
        end
      end
      eba_pkg::ST_GAP: begin
        // idle insertion counts as an active cycle: no release in here
        if (gap_left_q == 2'h0) begin
          state_d = eba_pkg::ST_CYCLE;
        end
      end
      eba_pkg::ST_CYCLE: begin
        if (acc_done_i) begin
          // interrupt fetches and saves end with last set, so arbitration runs between them
          state_d = (shared_own_q && cur_last_q) ? eba_pkg::ST_RELEASE : eba_pkg::ST_IDLE;
        end
      end
      eba_pkg::ST_RELEASE: begin
        state_d = eba_pkg::ST_RELEASED;
      end
      eba_pkg::ST_RELEASED: begin
        if (!plain_master) begin
          state_d = eba_pkg::ST_IDLE;
        end else if (release_request_n_i) begin
          state_d = eba_pkg::ST_ACQUIRE;
        end
      end
      eba_pkg::ST_REQUEST: begin
        if (!bus_ack_n_i) begin
          state_d = eba_pkg::ST_ACQUIRE;
        end
      end
      eba_pkg::ST_ACQUIRE: begin
        state_d = eba_pkg::ST_IDLE;
      end
      default: begin
        state_d = eba_pkg::ST_IDLE;
      end
    endcase
  end

  assign decide = (state_q == eba_pkg::ST_IDLE) &&
                  (state_d == eba_pkg::ST_GAP || state_d == eba_pkg::ST_CYCLE);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= eba_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // capture the access chosen for the next cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_m_q <= eba_pkg::M_CPU;
      cur_cs_q <= 2'h0;
      cur_wr_q <= 1'b0;
      cur_last_q <= 1'b1;
      cur_ref_q <= 1'b0;
      gap_left_q <= 2'h0;
    end else if (decide) begin
      cur_m_q <= sel_m;
      cur_cs_q <= sel_cs;
      cur_wr_q <= sel_wr;
      cur_last_q <= sel_last;
      cur_ref_q <= sel_is_ref;
      gap_left_q <= (need != 2'h0) ? 2'(need - 2'h1) : 2'h0;
    end else if (state_q == eba_pkg::ST_GAP && gap_left_q != 2'h0) begin
      gap_left_q <= 2'(gap_left_q - 2'h1);
    end
  end

  // previous access memory and empty-cycle count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_valid_q <= 1'b0;
      prev_rd_q <= 1'b0;
      prev_cs_q <= 2'h0;
      gap_q <= 2'h0;
    end else if (state_q == eba_pkg::ST_CYCLE && acc_done_i && !cur_ref_q) begin
      prev_valid_q <= 1'b1;
      prev_rd_q <= ~cur_wr_q;
      prev_cs_q <= cur_cs_q;
      gap_q <= 2'h0;
    end else if (state_q == eba_pkg::ST_RELEASE || state_q == eba_pkg::ST_ACQUIRE) begin
      // the arbitration cycle already separates the accesses
      prev_valid_q <= 1'b0;
    end else if (state_q == eba_pkg::ST_IDLE && gap_q != eba_pkg::GAP_SAT) begin
      gap_q <= 2'(gap_q + 2'h1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_q <= 1'b0;
      lock_m_q <= eba_pkg::M_CPU;
    end else if (state_q == eba_pkg::ST_CYCLE && acc_done_i) begin
      lock_q <= ~cur_last_q;
      lock_m_q <= cur_m_q;
    end
  end

  // shared ownership and request line for slave-style access
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shared_own_q <= 1'b0;
      bus_request_n_n_q <= 1'b1;
    end else if (state_d == eba_pkg::ST_REQUEST) begin
      bus_request_n_n_q <= 1'b0;
    end else if (state_q == eba_pkg::ST_REQUEST && state_d == eba_pkg::ST_ACQUIRE) begin
      shared_own_q <= 1'b1;
    end else if (state_d == eba_pkg::ST_RELEASE) begin
      shared_own_q <= 1'b0;
      bus_request_n_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      grant_n_q <= 1'b1;
    end else begin
      grant_n_q <= ~(state_d == eba_pkg::ST_RELEASED && plain_master);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      start_q <= (state_d == eba_pkg::ST_CYCLE) && (state_q != eba_pkg::ST_CYCLE);
      if (decide) begin
        // write data floats on the rise, read strobe waits for the fall
        late_q <= ~sel_wr & prev_valid_q & ~prev_rd_q & (gap_q == 2'h0);
      end
    end
  end

  assign start_o = start_q;
  assign start_master_o = start_q ? (3'h1 << cur_m_q) : 3'h0;
  assign cyc_cs_o = cur_cs_q;
  assign cyc_wr_o = cur_wr_q;
  assign rd_strobe_late_o = late_q & ~cur_wr_q;
  assign idle_insert_o = (state_q == eba_pkg::ST_GAP);
  assign release_grant_n_o = grant_n_q;
  assign bus_request_n_o = bus_request_n_n_q;
  // partial-share always drives; otherwise only the owner drives
  assign bus_drive_en_n_o = pshare ? 1'b0 :
                            slave_q ? ~(shared_own_q | state_q == eba_pkg::ST_RELEASE) :
                            ~(strap_done_q && state_q != eba_pkg::ST_RELEASED);
  assign ctrl_inactive_o = (state_q == eba_pkg::ST_RELEASE) || (state_q == eba_pkg::ST_ACQUIRE);
  // with monitoring, the internal bus is busy watching the foreign master
  assign periph_go_o = periph_req_i & (~monitor_en_i | bus_drive_en_n_o == 1'b0);
  assign cache_read_go_o = cpu_read_hit_i;

  a_float_granted: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !release_grant_n_o && !pshare |-> bus_drive_en_n_o)
    else $error("bus driven while grant asserted");
  a_lock_no_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_q == eba_pkg::ST_CYCLE && acc_done_i && !cur_last_q |=> state_q != eba_pkg::ST_RELEASE ##1
    state_q != eba_pkg::ST_RELEASED)
    else $error("bus released inside locked sequence");
  a_same_space_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    decide && prev_valid_q && prev_rd_q && !sel_wr && !sel_is_ref && sel_cs == prev_cs_q |=> start_o)
    else $error("idle inserted between same-space reads");
  a_wr_after_rd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    decide && prev_valid_q && prev_rd_q && sel_wr && !sel_is_ref && gap_q == 2'h0 |=> idle_insert_o)
    else $error("write after read without wait");
  a_gap_bounded: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(idle_insert_o) |-> ##[1:2] start_o)
    else $error("idle insertion exceeds two cycles");
  a_idle_cleared: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_q == eba_pkg::ST_ACQUIRE |=> !prev_valid_q)
    else $error("access history kept across ownership change");
  a_refresh_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    decide && ref_ok && !lock_q |=> cur_m_q == eba_pkg::M_REFRESH)
    else $error("refresh lost priority");
  a_grant_return: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_q == eba_pkg::ST_RELEASED && plain_master && release_request_n_i |=> release_grant_n_o ##1
    !bus_drive_en_n_o)
    else $error("grant not withdrawn after request negated");
  a_release_inactive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(state_q == eba_pkg::ST_RELEASED) |-> $past(ctrl_inactive_o))
    else $error("bus released without inactive controls");
  a_slave_ack: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_q == eba_pkg::ST_REQUEST && !bus_ack_n_i |-> !bus_request_n_o ##1 ctrl_inactive_o ##1
    !bus_drive_en_n_o)
    else $error("slave acquisition sequence broken");
  a_pshare_drive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pshare |-> !bus_drive_en_n_o && release_grant_n_o)
    else $error("partial-share mode floated the bus");

  c_master_release: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    state_q == eba_pkg::ST_RELEASE ##1 !release_grant_n_o);
  c_idle_two: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    idle_insert_o [*2] ##1 start_o);
  c_slave_cycle: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    slave_q && start_o);
  c_locked_burst: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    lock_q && start_o);

endmodule : eba_arbiter

// File: test/eba_far_side.sv
// far-side model: an external bus requester in master mode, the owning master in slave mode
// assumes the arbiter's link outputs change only on the rising edge of clk_i
`timescale 1ns/1ps
module eba_far_side (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // bench control
  input wire logic want_bus_i,
  input wire logic [3:0] ack_delay_i,
  // arbitration link
  input wire logic release_grant_n_i,
  input wire logic bus_request_n_i,
  output logic release_request_n_o,
  output logic bus_ack_n_o
);
  logic [3:0] wait_q;

  // request stays low until granted, so a handover is never withdrawn half way
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      release_request_n_o <= 1'h1;
    end else if (want_bus_i) begin
      release_request_n_o <= 1'h0;
    end else if (!release_grant_n_i) begin
      release_request_n_o <= 1'h1;
    end
  end

  // acknowledge only after a programmable delay, withdrawn as soon as the request goes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= 4'h0;
      bus_ack_n_o <= 1'h1;
    end else if (bus_request_n_i) begin
      wait_q <= 4'h0;
      bus_ack_n_o <= 1'h1;
    end else if (wait_q >= ack_delay_i) begin
      bus_ack_n_o <= 1'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : eba_far_side

// File: test/tb.sv
// self-checking bench for the bus ownership and idle-insertion block
// assumes the far-side model answers the link; the bench plays memory sequencer via acc_done_i
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic mode_slave_i = 1'h0;
  logic partial_share_enable_i = 1'h0;
  logic refresh_req_i = 1'h0, dma_req_i = 1'h0, dma_wr_i = 1'h0, dma_last_i = 1'h1;
  logic cpu_req_i = 1'h0, cpu_wr_i = 1'h0, cpu_last_i = 1'h1;
  logic [1:0] dma_cs_i = 2'h0, cpu_cs_i = 2'h0;
  logic acc_done_i = 1'h0, monitor_en_i = 1'h0, periph_req_i = 1'h1, cpu_read_hit_i = 1'h1;
  logic want_bus = 1'h0;
  logic start_o, cyc_wr_o, rd_strobe_late_o, idle_insert_o, release_grant_n_o, bus_request_n_o;
  logic bus_drive_en_n_o, ctrl_inactive_o, periph_go_o, cache_read_go_o, release_request_n_i, bus_ack_n_i;
  logic [2:0] start_master_o;
  logic [1:0] cyc_cs_o;
  logic seen_bus_request_n, seen_q;
  logic [3:0] idl;
  int n_fail = 0;
  int n_checks = 0;

  always #12.5 clk_i = ~clk_i;

  eba_arbiter i_eba_arbiter (.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_slave_i(mode_slave_i),
    .partial_share_enable_i(partial_share_enable_i), .space0_read_idle_count_i(2'h2),
    .space1_read_idle_count_i(2'h1), .space2_read_idle_count_i(2'h0), .space3_read_idle_count_i(2'h3),
    .refresh_req_i(refresh_req_i), .dma_req_i(dma_req_i), .dma_cs_i(dma_cs_i), .dma_wr_i(dma_wr_i),
    .dma_last_i(dma_last_i), .cpu_req_i(cpu_req_i), .cpu_cs_i(cpu_cs_i), .cpu_wr_i(cpu_wr_i),
    .cpu_last_i(cpu_last_i), .acc_done_i(acc_done_i), .start_o(start_o), .start_master_o(start_master_o),
    .cyc_cs_o(cyc_cs_o), .cyc_wr_o(cyc_wr_o), .rd_strobe_late_o(rd_strobe_late_o),
    .idle_insert_o(idle_insert_o), .release_request_n_i(release_request_n_i),
    .release_grant_n_o(release_grant_n_o), .bus_request_n_o(bus_request_n_o), .bus_ack_n_i(bus_ack_n_i),
    .bus_drive_en_n_o(bus_drive_en_n_o), .ctrl_inactive_o(ctrl_inactive_o), .monitor_en_i(monitor_en_i),
    .periph_req_i(periph_req_i), .periph_go_o(periph_go_o), .cpu_read_hit_i(cpu_read_hit_i),
    .cache_read_go_o(cache_read_go_o));

  eba_far_side i_eba_far_side (.clk_i(clk_i), .arst_n_i(arst_n_i), .want_bus_i(want_bus),
    .ack_delay_i(4'h3), .release_grant_n_i(release_grant_n_o), .bus_request_n_i(bus_request_n_o),
    .release_request_n_o(release_request_n_i), .bus_ack_n_o(bus_ack_n_i));

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset(input logic strap, input logic pshare);
    @(posedge clk_i);
    arst_n_i <= 1'h0;
    mode_slave_i <= strap;
    partial_share_enable_i <= pshare;
    acc_done_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
  endtask : do_reset

  task automatic set_req(input int m, input logic [1:0] cs, input logic wr, input logic last, input logic on);
    case (m)
      0: refresh_req_i <= on;
      1: begin
        dma_req_i <= on;
        dma_cs_i <= cs;
        dma_wr_i <= wr;
        dma_last_i <= last;
      end
      default: begin
        cpu_req_i <= on;
        cpu_cs_i <= cs;
        cpu_wr_i <= wr;
        cpu_last_i <= last;
      end
    endcase
  endtask : set_req

  // waits for the start pulse, counting inserted idle cycles on the way
  task automatic wait_start();
    idl = 4'h0;
    seen_bus_request_n = 1'h0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_i);
      if (bus_request_n_o === 1'h0) seen_bus_request_n = 1'h1;
      if (start_o === 1'h1) break;
      if (idle_insert_o === 1'h1) idl++;
    end
    chk("start_o", 4'h1, start_o);
  endtask : wait_start

  // done is left high; whoever comes next drops it
  task automatic end_acc(input int m);
    @(posedge clk_i);
    set_req(m, 2'h0, 1'h0, 1'h1, 1'h0);
    @(posedge clk_i);
    acc_done_i <= 1'h1;
  endtask : end_acc

  task automatic run(input int m, input logic [1:0] cs, input logic wr, input int gap,
                     input logic [3:0] exp_idle, input logic exp_late);
    if (gap == 0) set_req(m, cs, wr, 1'h1, 1'h1);
    @(posedge clk_i);
    acc_done_i <= 1'h0;
    if (gap > 0) begin
      repeat (gap) @(posedge clk_i);
      set_req(m, cs, wr, 1'h1, 1'h1);
    end
    wait_start();
    chk("idle cycles", exp_idle, idl);
    chk("start master", 4'(1 << m), start_master_o);
    chk("space", cs, cyc_cs_o);
    chk("direction", wr, cyc_wr_o);
    chk("late strobe", exp_late, rd_strobe_late_o);
    end_acc(m);
  endtask : run

  initial begin
    #(4000 * 25);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    do_reset(1'h0, 1'h0);
    chk("grant idle", 4'h1, release_grant_n_o);
    run(2, 2'h0, 1'h0, 2, 4'h0, 1'h0);
    run(2, 2'h1, 1'h0, 0, 4'h2, 1'h0);
    run(2, 2'h1, 1'h0, 0, 4'h0, 1'h0);
    run(2, 2'h3, 1'h1, 0, 4'h1, 1'h0);
    run(2, 2'h3, 1'h1, 0, 4'h0, 1'h0);
    run(2, 2'h0, 1'h0, 0, 4'h0, 1'h1);
    run(1, 2'h2, 1'h0, 0, 4'h2, 1'h0);
    run(1, 2'h0, 1'h1, 0, 4'h1, 1'h0);
    run(2, 2'h3, 1'h0, 0, 4'h0, 1'h1);
    run(2, 2'h0, 1'h0, 0, 4'h2, 1'h0);
    run(2, 2'h1, 1'h0, 5, 4'h0, 1'h0);
    // all three internal masters at once
    @(posedge clk_i);
    acc_done_i <= 1'h0;
    for (int i = 0; i < 3; i++) set_req(i, 2'h0, 1'h1, 1'h1, 1'h1);
    for (int i = 0; i < 3; i++) begin
      wait_start();
      chk("priority", 4'(1 << i), start_master_o);
      end_acc(i);
      @(posedge clk_i);
      acc_done_i <= 1'h0;
    end
    // release requested in the middle of a locked pair
    set_req(2, 2'h0, 1'h0, 1'h0, 1'h1);
    wait_start();
    @(posedge clk_i);
    want_bus <= 1'h1;
    cpu_last_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    // look between edges so the registered grant has settled
    @(negedge clk_i);
    chk("grant during cycle", 4'h1, release_grant_n_o);
    @(posedge clk_i);
    acc_done_i <= 1'h1;
    @(posedge clk_i);
    acc_done_i <= 1'h0;
    wait_start();
    chk("grant in locked pair", 4'h1, release_grant_n_o);
    end_acc(2);
    @(posedge clk_i);
    acc_done_i <= 1'h0;
    seen_q = 1'h0;
    for (int k = 0; k < 10 && release_grant_n_o !== 1'h0; k++) begin
      @(negedge clk_i);
      if (ctrl_inactive_o === 1'h1) seen_q = 1'h1;
    end
    chk("grant", 4'h0, release_grant_n_o);
    chk("controls parked", 4'h1, seen_q);
    chk("drive off", 4'h1, bus_drive_en_n_o);
    chk("periph free", 4'h1, periph_go_o);
    chk("cache hit", 4'h1, cache_read_go_o);
    @(posedge clk_i);
    monitor_en_i <= 1'h1;
    set_req(2, 2'h1, 1'h0, 1'h1, 1'h1);
    seen_q = 1'h0;
    repeat (4) begin
      @(negedge clk_i);
      if (start_o !== 1'h0) seen_q = 1'h1;
    end
    chk("start while released", 4'h0, seen_q);
    chk("periph held", 4'h0, periph_go_o);
    chk("cache hit held", 4'h1, cache_read_go_o);
    @(posedge clk_i);
    want_bus <= 1'h0;
    monitor_en_i <= 1'h0;
    wait_start();
    chk("idle after handover", 4'h0, idl);
    chk("grant back", 4'h1, release_grant_n_o);
    chk("drive on", 4'h0, bus_drive_en_n_o);
    end_acc(2);
    // slave strap; the partial-share bit must not take effect
    do_reset(1'h1, 1'h1);
    chk("slave floats", 4'h1, bus_drive_en_n_o);
    chk("slave no request", 4'h1, bus_request_n_o);
    run(2, 2'h1, 1'h0, 2, 4'h0, 1'h0);
    chk("slave requested", 4'h1, seen_bus_request_n);
    @(posedge clk_i);
    acc_done_i <= 1'h0;
    for (int k = 0; k < 10 && bus_drive_en_n_o !== 1'h1; k++) @(negedge clk_i);
    chk("slave released", 4'h1, bus_request_n_o);
    chk("slave floats after", 4'h1, bus_drive_en_n_o);
    // partial-share master
    do_reset(1'h0, 1'h1);
    chk("pshare drives", 4'h0, bus_drive_en_n_o);
    run(2, 2'h0, 1'h0, 2, 4'h0, 1'h0);
    chk("pshare no request", 4'h0, seen_bus_request_n);
    run(2, 2'h2, 1'h0, 5, 4'h0, 1'h0);
    chk("pshare space two", 4'h1, seen_bus_request_n);
    chk("pshare still drives", 4'h0, bus_drive_en_n_o);
    @(posedge clk_i);
    acc_done_i <= 1'h0;
    tally_and_finish();
  end
endmodule : tb
